/* src/cmp_timer_pkg.sv */
package cmp_timer_pkg;
  // Register byte addresses
  localparam logic [11:0] ADDR_TRIG_CTRL  = 12'h000;
  localparam logic [11:0] ADDR_OUT_CTRL   = 12'h004;
  localparam logic [11:0] ADDR_CONST_A    = 12'h008;
  localparam logic [11:0] ADDR_CONST_B    = 12'h00C;
  localparam logic [11:0] ADDR_COUNT      = 12'h010;
  localparam logic [11:0] ADDR_STATUS     = 12'h014;
  // timer_trigger_control fields
  localparam int          TRIG_EN_BIT     = 2;
  localparam int          EDGE_LO_BIT     = 3;
  localparam int          EDGE_HI_BIT     = 4;
  localparam logic [2:0]  TRIG_RSVD_VAL   = 3'h7;
  // out control fields: A in [1:0], B in [3:2], free-run start bit 4
  localparam int          OSA_LO_BIT      = 0;
  localparam int          OSB_LO_BIT      = 2;
  localparam int          RUN_BIT         = 4;
  localparam int          CLR_B_BIT       = 5;
  // Reset values
  localparam logic [1:0]  EDGE_RST        = 2'h0;
  localparam logic [1:0]  OSEL_RST        = 2'h0;
  localparam logic [7:0]  CONST_RST       = 8'hFF;
  // Output select codes
  localparam logic [1:0]  OSEL_KEEP       = 2'h0;
  localparam logic [1:0]  OSEL_LOW        = 2'h1;
  localparam logic [1:0]  OSEL_HIGH       = 2'h2;
  localparam logic [1:0]  OSEL_TOGGLE     = 2'h3;
  // Trigger edge codes
  localparam logic [1:0]  EDGE_NONE       = 2'h0;
  localparam logic [1:0]  EDGE_RISE       = 2'h1;
  localparam logic [1:0]  EDGE_FALL       = 2'h2;
  localparam logic [1:0]  EDGE_BOTH       = 2'h3;
endpackage

/* src/trig_edge_detect.sv */
`timescale 1ns/1ps
module trig_edge_detect
  import cmp_timer_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Trigger
  input  wire logic       trig_in,
  input  wire logic [1:0] edge_sel,
  output logic            start_pulse
);
  logic sync_a;
  logic sync_b;
  logic prev;
  wire  rise = sync_b & ~prev;
  wire  fall = ~sync_b & prev;
  wire  hit  = (edge_sel == EDGE_RISE && rise) ||
               (edge_sel == EDGE_FALL && fall) ||
               (edge_sel == EDGE_BOTH && (rise || fall));

  // Two stages before any edge logic; one event per edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_a      <= 1'b0;
      sync_b      <= 1'b0;
      prev        <= 1'b0;
      start_pulse <= 1'b0;
    end else begin
      sync_a      <= trig_in;
      sync_b      <= sync_a;
      prev        <= sync_b;
      start_pulse <= hit;
    end
  end
endmodule

/* src/compare_output_trigger_timer.sv */
`timescale 1ns/1ps
module compare_output_trigger_timer
  import cmp_timer_pkg::*;
#(
  parameter int CNT_W = 8
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Pins
  input  wire logic        external_trigger_pin,
  output logic             timer_output_pin
);
  initial begin
    if (CNT_W < 1 || CNT_W > 24) $error("CNT_W out of range");
  end

  logic [1:0]       trig_edge_sel;
  logic             trigger_start_enable;
  logic [1:0]       osel_a;
  logic [1:0]       osel_b;
  logic             clear_on_b;
  logic [CNT_W-1:0] constant_reg_a;
  logic [CNT_W-1:0] constant_reg_b;
  logic [CNT_W-1:0] count_value;
  logic             up_counter;
  logic             start_pulse;

  function automatic logic apply_sel(input logic [1:0] sel, input logic cur);
    logic r;
    r = cur;
    unique case (sel)
      OSEL_KEEP:   r = cur;
      OSEL_LOW:    r = 1'b0;
      OSEL_HIGH:   r = 1'b1;
      OSEL_TOGGLE: r = ~cur;
    endcase
    return r;
  endfunction

  trig_edge_detect u_edge (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .trig_in     (external_trigger_pin),
    .edge_sel    (trig_edge_sel),
    .start_pulse (start_pulse)
  );

  // Bus decode
  wire setup_ph  = psel & ~penable;
  wire access_ph = psel & penable;
  wire wr_en     = access_ph & pwrite & pready;
  wire hit_trig  = (paddr == ADDR_TRIG_CTRL);
  wire hit_out   = (paddr == ADDR_OUT_CTRL);
  wire hit_ca    = (paddr == ADDR_CONST_A);
  wire hit_cb    = (paddr == ADDR_CONST_B);
  wire hit_cnt   = (paddr == ADDR_COUNT);
  wire hit_stat  = (paddr == ADDR_STATUS);
  wire mapped    = hit_trig | hit_out | hit_ca | hit_cb | hit_cnt | hit_stat;
  wire wr_cnt    = wr_en & hit_cnt;

  // Compare logic
  wire match_a   = (count_value == constant_reg_a);
  wire match_b   = (count_value == constant_reg_b);
  wire clear_hit = match_a | (clear_on_b & match_b);
  wire next_pin_a = apply_sel(osel_a, timer_output_pin);
  wire next_pin   = match_b ? apply_sel(osel_b, next_pin_a & match_a | timer_output_pin & ~match_a)
                            : next_pin_a;

  // Counter run state: trigger starts it, clearing match halts it while trigger start is enabled
  wire start_evt  = trigger_start_enable & start_pulse;
  wire halt_evt   = trigger_start_enable & clear_hit & up_counter;
  wire [31:0] rd_trig = {24'h0, TRIG_RSVD_VAL, trig_edge_sel, trigger_start_enable, 2'h0};
  wire [31:0] rd_out  = {26'h0, clear_on_b, up_counter, osel_b, osel_a};
  wire [31:0] rd_data = hit_trig ? rd_trig :
                        hit_out  ? rd_out :
                        hit_ca   ? 32'(constant_reg_a) :
                        hit_cb   ? 32'(constant_reg_b) :
                        hit_cnt  ? 32'(count_value) :
                        hit_stat ? {30'h0, match_b, match_a} : 32'h0;

  // No wait state: ready in the first access cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_ph;
      prdata  <= setup_ph ? rd_data : 32'h0;
      pslverr <= setup_ph & ~mapped;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      trig_edge_sel        <= EDGE_RST;
      trigger_start_enable <= 1'b0;
    end else if (wr_en && hit_trig) begin
      trig_edge_sel        <= pwdata[EDGE_HI_BIT:EDGE_LO_BIT];
      trigger_start_enable <= pwdata[TRIG_EN_BIT];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      osel_a     <= OSEL_RST;
      osel_b     <= OSEL_RST;
      clear_on_b <= 1'b0;
    end else if (wr_en && hit_out) begin
      osel_a     <= pwdata[OSA_LO_BIT+:2];
      osel_b     <= pwdata[OSB_LO_BIT+:2];
      clear_on_b <= pwdata[CLR_B_BIT];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      constant_reg_a <= CNT_W'(CONST_RST);
      constant_reg_b <= CNT_W'(CONST_RST);
    end else begin
      if (wr_en && hit_ca) constant_reg_a <= pwdata[CNT_W-1:0];
      if (wr_en && hit_cb) constant_reg_b <= pwdata[CNT_W-1:0];
    end
  end

  // Software run bit writes also start/stop; trigger start wins over halt
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      up_counter <= 1'b0;
    end else if (start_evt) begin
      up_counter <= 1'b1;
    end else if (halt_evt) begin
      up_counter <= 1'b0;
    end else if (wr_en && hit_out) begin
      up_counter <= pwdata[RUN_BIT];
    end
  end

  // Match A, or match B with clear_on_b, clears the counter to zero, otherwise count while running
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_value <= '0;
    end else if (wr_cnt) begin
      count_value <= pwdata[CNT_W-1:0];
    end else if (up_counter) begin
      count_value <= clear_hit ? '0 : count_value + 1'b1;
    end
  end

  // Pin only moves on a match while counting; low from reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_output_pin <= 1'b0;
    end else if (up_counter && (match_a || match_b)) begin
      timer_output_pin <= next_pin;
    end
  end
endmodule

/* test/cmp_timer_monitor.sv */
`timescale 1ns/1ps
module cmp_timer_monitor
  import cmp_timer_pkg::*;
#(
  parameter int CNT_W = 8
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Pins
  input wire logic        external_trigger_pin,
  input wire logic        timer_output_pin
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence rd_trig;
    pready && !pwrite && paddr == ADDR_TRIG_CTRL;
  endsequence
  sequence setup_ph;
    psel && !penable;
  endsequence
  rsvd_ones_a: assert property (rd_trig |-> prdata[7:5] == TRIG_RSVD_VAL) else $error("reserved bits");
  trig_upper_a: assert property (rd_trig |-> prdata[31:8] == 24'h000000) else $error("control upper bits");
  out_reset_a: assert property ($fell(sys_rst) |-> !timer_output_pin) else $error("output after reset");
  err_unmap_a: assert property (pready && paddr > ADDR_STATUS |-> pslverr) else $error("unmapped no error");
  ready_once_a: assert property (pready |=> !pready) else $error("ready too long");
  ready_ans_a: assert property (setup_ph |=> pready) else $error("ready late");
  idle_data_a: assert property (!pready |-> prdata == 32'h00000000) else $error("read data idle");
  err_only_a: assert property (pslverr |-> pready) else $error("error without ready");
endmodule
bind compare_output_trigger_timer cmp_timer_monitor #(.CNT_W(CNT_W)) u_monitor (.clk(clk), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .external_trigger_pin(external_trigger_pin),
  .timer_output_pin(timer_output_pin));

/* test/trig_source.sv */
`timescale 1ns/1ps
module trig_source (
  // Clock and request
  input  wire logic clk,
  input  wire logic fire,
  // Pins
  input  wire logic timer_output_pin,
  output logic      external_trigger_pin
);
  logic [1:0] hold_cnt;
  initial external_trigger_pin = 1'b0;
  initial hold_cnt = 2'h0;
  // Each level held a few clocks so a slow input stage still sees it
  always @(posedge clk) begin
    if (fire && hold_cnt == 2'h0) begin
      external_trigger_pin <= ~external_trigger_pin;
      hold_cnt <= 2'h3;
    end else if (hold_cnt != 2'h0) begin
      hold_cnt <= hold_cnt - 2'h1;
    end
  end
endmodule

/* test/compare_output_trigger_timer_bench.sv */
`timescale 1ns/1ps
module compare_output_trigger_timer_bench;
  import cmp_timer_pkg::*;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e;} row_t;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, trig, pin, fire, p, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  int failures = 0;
  int samples_checked = 0;
  row_t rows[5] = '{'{ADDR_TRIG_CTRL, 32'h1C, 32'hFC}, '{ADDR_TRIG_CTRL, 32'hFF, 32'hFC},
    '{ADDR_TRIG_CTRL, 32'h08, 32'hE8}, '{ADDR_CONST_A, 32'h5A, 32'h5A}, '{12'h020, 32'h05, 32'h00}};
  logic [7:0] steps[7] = '{8'h0C, 8'h0C, 8'h14, 8'h14, 8'h1C, 8'h04, 8'h18};
  logic tog[7] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  compare_output_trigger_timer u_compare_output_trigger_timer (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .external_trigger_pin(trig), .timer_output_pin(pin));
  trig_source u_trig_source (.clk(clk), .fire(fire), .timer_output_pin(pin), .external_trigger_pin(trig));
  task summarize;
    if (failures == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
    r = prdata;
    err = pslverr;
    if (n >= 50) begin failures++; summarize(); end
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask
  task wait_pin(input logic lvl);
    int n;
    for (n = 0; n < 100 && pin !== lvl; n++) @(posedge clk);
    if (n >= 100) begin failures++; summarize(); end
  endtask
  initial begin clk = 1'b0; forever #2.5 clk = ~clk; end
  initial begin
    sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0; fire = 1'b0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      apb(rows[i].a, 1'b1, rows[i].d);
      apb(rows[i].a, 1'b0, 32'h0);
      check(r, rows[i].e);
      check(err, rows[i].a > ADDR_STATUS);
    end
    apb(ADDR_CONST_A, 1'b1, 32'h03);
    apb(ADDR_CONST_B, 1'b1, 32'h01);
    apb(ADDR_OUT_CTRL, 1'b1, 32'h10 | OSEL_HIGH); wait_pin(1'b1);
    apb(ADDR_OUT_CTRL, 1'b1, 32'h10 | OSEL_LOW); wait_pin(1'b0);
    apb(ADDR_OUT_CTRL, 1'b1, 32'h10 | OSEL_TOGGLE); wait_pin(1'b1); wait_pin(1'b0);
    apb(ADDR_OUT_CTRL, 1'b1, 32'h10 | OSEL_KEEP);
    p = pin;
    repeat (20) @(posedge clk);
    check(pin, p);
    apb(ADDR_OUT_CTRL, 1'b1, 32'h10 | OSEL_LOW); wait_pin(1'b0);
    apb(ADDR_OUT_CTRL, 1'b1, 32'h10 | (OSEL_HIGH << 2) | OSEL_KEEP); wait_pin(1'b1);
    // Stop free run; only trigger starts may move the counter now
    apb(ADDR_OUT_CTRL, 1'b1, 32'h00 | OSEL_TOGGLE);
    apb(ADDR_COUNT, 1'b1, 32'h00);
    for (int i = 0; i < 7; i++) begin
      p = pin;
      apb(ADDR_TRIG_CTRL, 1'b1, {24'h0, steps[i]});
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      repeat (30) @(posedge clk);
      check(pin, p ^ tog[i]);
    end
    apb(ADDR_OUT_CTRL, 1'b0, 32'h0);
    check(r & 32'h10, 32'h0);
    sys_rst <= 1'b1;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    check(pin, 1'b0);
    apb(ADDR_TRIG_CTRL, 1'b0, 32'h0);
    check(r, 32'hE0);
    summarize();
  end
endmodule
